// >>> pscl_consts.vh
// Constants of the serial configuration loader.
`ifndef PSCL_CONSTS_VH
`define PSCL_CONSTS_VH
`define PSCL_WORD_W        25
`define PSCL_SENS_HI       24
`define PSCL_SENS_LO       17
`define PSCL_BLIND_HI      16
`define PSCL_BLIND_LO      13
`define PSCL_PULSE_HI      12
`define PSCL_PULSE_LO      11
`define PSCL_WIN_HI        10
`define PSCL_WIN_LO        9
`define PSCL_MODE_HI       8
`define PSCL_MODE_LO       7
`define PSCL_SRC_HI        6
`define PSCL_SRC_LO        5
`define PSCL_MODE_FORCED   2'h0
`define PSCL_MODE_PERIODIC 2'h1
`define PSCL_MODE_WAKE     2'h2
`define PSCL_SRC_BAND      2'h0
`define PSCL_SRC_LOW       2'h1
`define PSCL_SRC_TEMP      2'h3
`define PSCL_RESET_WORD    25'h0000010
`define PSCL_SYS_DIV       16'd2750
`define PSCL_SAMPLE_TICKS  5'd1
`define PSCL_IDLE_TICKS    5'd16
`define PSCL_PERIOD_TICKS  10'd511
`define PSCL_HALF_SEC      14'd16383
`endif

// >>> pscl_tick_gen.v
// System clock enable divider for the loader.
`default_nettype none
`include "pscl_consts.vh"
module pscl_tick_gen #(
    parameter [15:0] DIV = `PSCL_SYS_DIV
) (
    input  wire ref_clk,
    input  wire rst_n,
    output reg  tick
);
    reg [15:0] cnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt == DIV - 16'h0001) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> pscl_loader.v
// Serial configuration loader and alarm event control.
`default_nettype none
`include "pscl_consts.vh"
module pscl_loader #(
    parameter [15:0] SYS_DIV = `PSCL_SYS_DIV,
    parameter [13:0] HALF_SEC = `PSCL_HALF_SEC
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        config_serial_in,
    input  wire        link_in,
    input  wire        motion_pulse,
    input  wire        motion_sign,
    input  wire        host_busy,
    output reg  [24:0] alarm_event_config_word,
    output reg  [7:0]  sensitivity,
    output reg  [1:0]  source_select,
    output reg         link_out,
    output reg         link_oe,
    output reg         blind_active
);
    // ****************************************
    // Input synchronisers and system tick
    // ****************************************
    reg  [1:0] ser_sync;
    reg  [1:0] link_sync;
    reg        ser_prev;
    reg        link_prev;
    wire       tick;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_sync  <= 2'h0;
            link_sync <= 2'h0;
            ser_prev  <= 1'b0;
            link_prev <= 1'b0;
        end else begin
            ser_sync  <= {ser_sync[0], config_serial_in};
            link_sync <= {link_sync[0], link_in};
            ser_prev  <= ser_sync[1];
            link_prev <= link_sync[1];
        end
    end
    wire ser_rise  = ser_sync[1] & ~ser_prev;
    wire link_fall = ~link_sync[1] & link_prev;
    pscl_tick_gen #(.DIV(SYS_DIV)) u_tick (
        .ref_clk(ref_clk),
        .rst_n  (rst_n),
        .tick   (tick)
    );
    // ****************************************
    // Serial receiver
    // ****************************************
    // Power-up gate: nothing is taken until the line has idled low.
    reg        armed;
    reg [4:0]  low_cnt;
    reg [24:0] shift;
    reg [5:0]  nbits;
    reg [4:0]  idle_cnt;
    reg [4:0]  samp_cnt;
    reg        sampling;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed    <= 1'b0;
            low_cnt  <= 5'h00;
            shift    <= 25'h0000000;
            nbits    <= 6'h00;
            idle_cnt <= 5'h00;
            samp_cnt <= 5'h00;
            sampling <= 1'b0;
            alarm_event_config_word <= `PSCL_RESET_WORD;
        end else if (!armed) begin
            if (ser_sync[1])
                low_cnt <= 5'h00;
            else if (tick && low_cnt == `PSCL_IDLE_TICKS - 5'd1)
                armed <= 1'b1;
            else if (tick)
                low_cnt <= low_cnt + 5'h01;
        end else begin
            if (ser_rise) begin
                sampling <= 1'b1;
                samp_cnt <= 5'h00;
                idle_cnt <= 5'h00;
            end else if (sampling && tick) begin
                // Sample once one system clock has passed, inside the hold time.
                if (samp_cnt == `PSCL_SAMPLE_TICKS) begin
                    sampling <= 1'b0;
                    shift    <= {shift[23:0], ser_sync[1]};
                    if (nbits != 6'h3f)
                        nbits <= nbits + 6'h01;
                end else begin
                    samp_cnt <= samp_cnt + 5'h01;
                end
            end else if (tick && !sampling && nbits != 6'h00) begin
                if (idle_cnt == `PSCL_IDLE_TICKS) begin
                    // Short words are dropped; at least a full word must arrive.
                    if (nbits >= 6'd25)
                        alarm_event_config_word <= shift;
                    nbits    <= 6'h00;
                    idle_cnt <= 5'h00;
                end else begin
                    idle_cnt <= idle_cnt + 5'h01;
                end
            end
        end
    end
    // ****************************************
    // Field decode
    // ****************************************
    wire [3:0] blind_f = alarm_event_config_word[`PSCL_BLIND_HI:`PSCL_BLIND_LO];
    wire [1:0] pulse_f = alarm_event_config_word[`PSCL_PULSE_HI:`PSCL_PULSE_LO];
    wire [1:0] win_f   = alarm_event_config_word[`PSCL_WIN_HI:`PSCL_WIN_LO];
    wire [1:0] mode_f  = alarm_event_config_word[`PSCL_MODE_HI:`PSCL_MODE_LO];
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sensitivity   <= 8'h00;
            source_select <= `PSCL_SRC_BAND;
        end else begin
            sensitivity   <= alarm_event_config_word[`PSCL_SENS_HI:`PSCL_SENS_LO];
            source_select <= alarm_event_config_word[`PSCL_SRC_HI:`PSCL_SRC_LO];
        end
    end
    // ****************************************
    // Alarm event unit
    // ****************************************
    // Time is counted in half seconds of the system tick.
    reg [13:0] half_cnt;
    reg        half_tick;
    reg [4:0]  blind_left;
    reg [4:0]  win_left;
    reg [2:0]  pulses;
    reg        last_sign;
    reg [9:0]  per_cnt;
    wire       clear_alarm = link_fall && (mode_f == `PSCL_MODE_WAKE);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_cnt  <= 14'h0000;
            half_tick <= 1'b0;
        end else begin
            half_tick <= 1'b0;
            if (clear_alarm) begin
                // Restarting here keeps a blind time from being cut short by a stale count.
                half_cnt <= 14'h0000;
            end else if (tick) begin
                if (half_cnt == HALF_SEC) begin
                    half_cnt  <= 14'h0000;
                    half_tick <= 1'b1;
                end else begin
                    half_cnt <= half_cnt + 14'h0001;
                end
            end
        end
    end
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            blind_left   <= 5'h00;
            blind_active <= 1'b0;
            win_left     <= 5'h00;
            pulses       <= 3'h0;
            last_sign    <= 1'b0;
            per_cnt      <= 10'h000;
            link_out     <= 1'b0;
            link_oe      <= 1'b0;
        end else begin
            blind_active <= (blind_left != 5'h00);
            if (link_fall && mode_f == `PSCL_MODE_WAKE) begin
                link_out   <= 1'b0;
                link_oe    <= 1'b0;
                blind_left <= {1'b0, blind_f} + 5'h01;
                pulses     <= 3'h0;
                win_left   <= 5'h00;
            end else if (half_tick && blind_left != 5'h00) begin
                blind_left <= blind_left - 5'h01;
            end
            if (mode_f == `PSCL_MODE_PERIODIC && !host_busy) begin
                per_cnt <= (tick) ? per_cnt + 10'h001 : per_cnt;
                if (tick && per_cnt == `PSCL_PERIOD_TICKS) begin
                    per_cnt  <= 10'h000;
                    link_out <= 1'b1;
                    link_oe  <= 1'b1;
                end else if (tick) begin
                    link_oe <= 1'b0;
                end
            end else if (mode_f == `PSCL_MODE_WAKE) begin
                // Detection is fed by the band-pass path whatever source is read out.
                if (half_tick && win_left != 5'h00)
                    win_left <= win_left - 5'h01;
                else if (half_tick)
                    pulses <= 3'h0;
                if (motion_pulse && blind_left == 5'h00 && !link_out && !host_busy) begin
                    last_sign <= motion_sign;
                    if (pulses == 3'h0 || motion_sign != last_sign) begin
                        if (pulses == 3'h0)
                            // Each step of the window field is four half seconds.
                            win_left <= {1'b0, win_f, 2'b00} + 5'h04;
                        if (pulses == {1'b0, pulse_f}) begin
                            link_out <= 1'b1;
                            link_oe  <= 1'b1;
                            pulses   <= 3'h0;
                        end else begin
                            pulses <= pulses + 3'h1;
                        end
                    end
                end
            end else begin
                link_out <= 1'b0;
                link_oe  <= 1'b0;
                per_cnt  <= 10'h000;
            end
        end
    end
endmodule
`default_nettype wire

// >>> pscl_monitor.sv
// Port checker for the configuration loader.
`default_nettype none
module pscl_monitor (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        config_serial_in,
    input wire logic        link_in,
    input wire logic [24:0] alarm_event_config_word,
    input wire logic [7:0]  sensitivity,
    input wire logic [1:0]  source_select,
    input wire logic        link_out,
    input wire logic        link_oe,
    input wire logic        blind_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [1:0] md = alarm_event_config_word[8:7];
    chk_sens_copy: assert property (
        sensitivity == $past(alarm_event_config_word[24:17]))
        else $error("sensitivity differs from word");
    chk_src_copy: assert property (
        source_select == $past(alarm_event_config_word[6:5]))
        else $error("source differs from word");
    chk_forced_quiet: assert property ($rose(link_oe) |-> $past(md) != 2'h0)
        else $error("interrupt in forced mode");
    chk_reserved_quiet: assert property ($rose(link_oe) |-> $past(md) != 2'h3)
        else $error("interrupt in reserved mode");
    chk_period_drop: assert property (
        $rose(link_oe) && md == 2'h1 |-> ##[1:5] !link_oe)
        else $error("periodic drive not released");
    chk_alarm_hold: assert property (
        link_out && link_in && md == 2'h2 |=> link_out)
        else $error("alarm dropped without clear");
    chk_blind_start: assert property (
        $fell(link_in) && link_out && md == 2'h2 |-> ##[1:12] blind_active)
        else $error("blind time not started");
    chk_blind_len: assert property ($rose(blind_active) |-> blind_active[*3])
        else $error("blind time too short");
    chk_load_idle: assert property (
        $changed(alarm_event_config_word) |-> !$past(config_serial_in, 8))
        else $error("word latched while line busy");
endmodule
bind pscl_loader pscl_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
    .config_serial_in(config_serial_in), .link_in(link_in),
    .alarm_event_config_word(alarm_event_config_word), .sensitivity(sensitivity),
    .source_select(source_select), .link_out(link_out), .link_oe(link_oe),
    .blind_active(blind_active));
`default_nettype wire

// >>> pscl_host.sv
// Controller model that shifts configuration words in.
`default_nettype none
module pscl_host (
    input  wire logic ref_clk,
    output var  logic config_serial_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial config_serial_in = 1'b0;
    // Each bit takes four system ticks, well inside the allowed pause.
    task automatic send(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            config_serial_in <= 1'b0;
            repeat (2) @(posedge ref_clk);
            config_serial_in <= 1'b1;
            repeat (2) @(posedge ref_clk);
            config_serial_in <= w[i];
            repeat (12) @(posedge ref_clk);
        end
        config_serial_in <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test_pscl_serial_config_loader.sv
// Self-checking bench for the configuration loader.
`default_nettype none
module test_pir_serial_config_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        config_serial_in;
    logic        motion_pulse = 1'b0;
    logic        motion_sign = 1'b0;
    logic        host_low = 1'b0;
    logic        busy = 1'b0;
    logic [24:0] word;
    logic [7:0]  sens;
    logic [1:0]  src;
    logic        link_out;
    logic        link_oe;
    logic        blind;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          n;
    // The board pulls the link wire low when nobody drives it.
    wire         link_in = host_low ? 1'b0 : (link_oe & link_out);
    always #4 ref_clk = ~ref_clk;
    pscl_host host (.ref_clk(ref_clk), .config_serial_in(config_serial_in));
    pscl_loader #(.SYS_DIV(16'h4), .HALF_SEC(14'h3)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .config_serial_in(config_serial_in), .link_in(link_in), .motion_pulse(motion_pulse),
        .motion_sign(motion_sign), .host_busy(busy), .alarm_event_config_word(word),
        .sensitivity(sens), .source_select(src), .link_out(link_out), .link_oe(link_oe),
        .blind_active(blind));
    function automatic logic [24:0] mk(input logic [7:0] s, input logic [3:0] b,
        input logic [1:0] m, input logic [1:0] f);
        return {s, b, 2'h1, 2'h0, m, f, 5'h10};
    endfunction
    task automatic chk_val(input logic [24:0] a, input logic [24:0] e, input string m);
        cmp_count++;
        if (a !== e) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic load(input logic [24:0] w, input int bits);
        host.send({7'h0, w}, bits);
        repeat (100) @(posedge ref_clk);
    endtask
    task automatic pulse(input logic s);
        motion_pulse <= 1'b1;
        motion_sign <= s;
        @(posedge ref_clk);
        motion_pulse <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wait_rise(output int c);
        c = 0;
        while (link_oe !== 1'b0 && c < 3000) begin
            @(posedge ref_clk);
            c++;
        end
        while (link_oe !== 1'b1 && c < 3000) begin
            @(posedge ref_clk);
            c++;
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (80) @(posedge ref_clk);
        chk_val(word, 25'h10, "reset word");
        chk_val({15'h0, sens, src}, 25'h0, "reset fields");
        load(mk(8'h5a, 4'h0, 2'h1, 2'h3), 10);
        chk_val(word, 25'h10, "short word taken");
        load(mk(8'ha5, 4'h0, 2'h1, 2'h3), 25);
        chk_val(word, mk(8'ha5, 4'h0, 2'h1, 2'h3), "word");
        chk_val({15'h0, sens, src}, {15'h0, 8'ha5, 2'h3}, "fields");
        wait_rise(n);
        wait_rise(n);
        chk_val(25'(n), 25'h800, "interrupt period");
        load(mk(8'h00, 4'h0, 2'h0, 2'h0), 27);
        chk_val(word, mk(8'h00, 4'h0, 2'h0, 2'h0), "long word");
        pulse(1'b0);
        pulse(1'b1);
        wait_rise(n);
        chk_val(25'(n), 25'hbb8, "interrupt in forced mode");
        load(mk(8'h01, 4'hf, 2'h2, 2'h1), 25);
        pulse(1'b0);
        repeat (6) @(posedge ref_clk);
        chk_val({24'h0, link_out & link_oe}, 25'h0, "alarm early");
        pulse(1'b1);
        repeat (20) @(posedge ref_clk);
        chk_val({24'h0, link_out & link_oe}, 25'h1, "alarm missing");
        host_low <= 1'b1;
        repeat (12) @(posedge ref_clk);
        host_low <= 1'b0;
        chk_val({24'h0, blind}, 25'h1, "blind not started");
        pulse(1'b0);
        pulse(1'b1);
        repeat (2) @(posedge ref_clk);
        chk_val({24'h0, link_out & link_oe}, 25'h0, "alarm in blind time");
        repeat (300) @(posedge ref_clk);
        busy <= 1'b1;
        pulse(1'b0);
        pulse(1'b1);
        repeat (2) @(posedge ref_clk);
        chk_val({24'h0, link_out & link_oe}, 25'h0, "alarm while host busy");
        busy <= 1'b0;
        pulse(1'b0);
        pulse(1'b1);
        repeat (2) @(posedge ref_clk);
        chk_val({24'h0, link_out & link_oe}, 25'h1, "alarm after blind time");
        rst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        load(mk(8'h3c, 4'h1, 2'h3, 2'h0), 25);
        chk_val(word, 25'h10, "word taken before arming");
        load(mk(8'h3c, 4'h1, 2'h3, 2'h0), 25);
        chk_val(word, mk(8'h3c, 4'h1, 2'h3, 2'h0), "word after arming");
        pulse(1'b0);
        pulse(1'b1);
        wait_rise(n);
        chk_val(25'(n), 25'hbb8, "interrupt in reserved mode");
        tally_and_finish();
    end
endmodule
`default_nettype wire
